// [run_step_pkg.sv]
/*
  constants, types and register map for the run/step and breakpoint control block.
  assumes one 40 MHz system clock and a plain register port with 8-bit byte addresses.
*/
package run_step_pkg;

  localparam int STORE_DEPTH     = 256;
  localparam int STORE_IDX_W     = 8;
  localparam int PROC_ADDR_W     = 13;
  localparam int INSN_W          = 16;
  localparam int EXT_W           = 8;
  localparam int BUS_ADDR_W      = 8;
  localparam int BUS_DATA_W      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_FORCE  = 8'h04;
  localparam logic [7:0] REG_INSN   = 8'h08;
  localparam logic [7:0] REG_EXT    = 8'h0C;
  localparam logic [7:0] REG_COMMIT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  localparam int CTRL_RUN        = 0;
  localparam int CTRL_STEP       = 1;
  localparam int CTRL_FORCE      = 2;
  localparam int CTRL_ONBOARD    = 3;
  localparam logic [3:0] CTRL_RESET = 4'h8;

  localparam int COMMIT_BREAKPOINT_FLAG     = 0;

  localparam int STAT_HALT_N     = 0;
  localparam int STAT_STATE      = 1;
  localparam int STAT_BREAKPOINT_FLAG       = 3;
  localparam int STAT_ADDR       = 8;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SYS_CLK_PERIOD_NS = 25;
  localparam int WRITE_PULSE_NS    = 100;
  localparam int WRITE_PULSE_CYC   = (WRITE_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int WPULSE_W          = 3;

  typedef enum logic [1:0] {
    ST_HALTED = 2'b00,
    ST_STEP   = 2'b01,
    ST_RUN    = 2'b11
  } run_state_e;

  typedef struct packed {
    logic              breakpoint_flag;
    logic [EXT_W-1:0]  ext;
    logic [INSN_W-1:0] insn;
  } store_word_s;

endpackage : run_step_pkg

// [run_step_breakpoint_control.sv]
/*
  run/step and breakpoint control with the writable program store, forced
  instruction latch, halt/reset gating and coprocessor clock gating.
  assumes the machine clock, processor address and external halt/reset arrive
  as pins asynchronous to sys_clk; the monitor reaches the registers over a
  plain address/strobe port with read data one cycle after the read strobe.
*/
// Local design decisions: the address-and-strobe port and the address map.
//
// Contract
// - inputs run, step, breakpoint, clock; halt out
// - breakpoint comes from addressed store word
// - wait mode: step gives one cycle
// - run mode: run until wait or breakpoint
// - store holds 256 words of 16+8+1
// - any location may hold a breakpoint
// - store decodes low address bits only
// - store disabled means external write cycle
// - register read via low address lines
// - instruction from store or forced latch
// - external halt/reset gated to run mode
// - coprocessor clock gated during halt
`timescale 1ns/100ps

module run_step_breakpoint_control
  import run_step_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic [BUS_ADDR_W-1:0]  bus_addr,
  input  wire logic [BUS_DATA_W-1:0]  bus_wdata,
  input  wire logic                   bus_wr,
  input  wire logic                   bus_rd,
  output logic      [BUS_DATA_W-1:0]  bus_rdata,
  input  wire logic                   mclk_pin,
  input  wire logic [PROC_ADDR_W-1:0] proc_addr_pin,
  input  wire logic                   ext_halt_n_pin,
  input  wire logic                   ext_reset_n_pin,
  output logic                        proc_halt_n,
  output logic                        proc_reset_n,
  output logic                        coproc_mclk,
  output store_word_s                 insn_out,
  output logic                        insn_oe,
  output logic                        ext_store_write_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic                   mclk_s1, mclk_s2, mclk_d;
  logic                   xhalt_s1, xhalt_s2, xrst_s1, xrst_s2;
  logic [PROC_ADDR_W-1:0] addr_s1, addr_s2;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_s1  <= 1'b1;
      mclk_s2  <= 1'b1;
      mclk_d   <= 1'b1;
      xhalt_s1 <= 1'b1;
      xhalt_s2 <= 1'b1;
      xrst_s1  <= 1'b1;
      xrst_s2  <= 1'b1;
      addr_s1  <= '0;
      addr_s2  <= '0;
    end else begin
      mclk_s1  <= mclk_pin;
      mclk_s2  <= mclk_s1;
      mclk_d   <= mclk_s2;
      xhalt_s1 <= ext_halt_n_pin;
      xhalt_s2 <= xhalt_s1;
      xrst_s1  <= ext_reset_n_pin;
      xrst_s2  <= xrst_s1;
      addr_s1  <= proc_addr_pin;
      addr_s2  <= addr_s1;
    end
  end

  logic                   fall;
  logic [STORE_IDX_W-1:0] idx;
  assign fall = mclk_d & ~mclk_s2;
  assign idx  = addr_s2[STORE_IDX_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // register port
  logic [3:0]        ctrl, next_ctrl;
  logic [INSN_W-1:0] force_insn, next_force_insn;
  logic [INSN_W-1:0] stage_insn, next_stage_insn;
  logic [EXT_W-1:0]  stage_ext, next_stage_ext;
  logic [BUS_DATA_W-1:0] next_rdata;
  logic              commit_wr, step_wr;
  run_state_e        state, next_state;
  store_word_s       store [STORE_DEPTH];
  store_word_s       cur_word;

  assign cur_word  = store[idx];
  assign commit_wr = bus_wr && (bus_addr == REG_COMMIT);
  assign step_wr   = bus_wr && (bus_addr == REG_CTRL) && bus_wdata[CTRL_STEP];

  always_comb begin
    next_ctrl       = ctrl;
    next_force_insn = force_insn;
    next_stage_insn = stage_insn;
    next_stage_ext  = stage_ext;
    next_rdata      = '0;
    if (bus_wr) begin
      case (bus_addr)
        REG_CTRL: begin
          next_ctrl = {bus_wdata[CTRL_ONBOARD], bus_wdata[CTRL_FORCE],
                       1'b0, bus_wdata[CTRL_RUN]};
        end
        REG_FORCE: next_force_insn = bus_wdata;
        REG_INSN:  next_stage_insn = bus_wdata;
        REG_EXT:   next_stage_ext  = bus_wdata[EXT_W-1:0];
        default: ;
      endcase
    end
    if (bus_rd) begin
      case (bus_addr)
        REG_CTRL:   next_rdata = {12'h000, ctrl};
        REG_FORCE:  next_rdata = force_insn;
        REG_INSN:   next_rdata = cur_word.insn;
        REG_EXT:    next_rdata = {8'h00, cur_word.ext};
        REG_COMMIT: next_rdata = {15'h0000, cur_word.breakpoint_flag};
        REG_STATUS: begin
          // low address byte shows a register forced out by execute-indirect
          next_rdata = {addr_s2[7:0], 4'h0, cur_word.breakpoint_flag, state, proc_halt_n};
        end
        default:    next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl       <= CTRL_RESET;
      force_insn <= '0;
      stage_insn <= '0;
      stage_ext  <= '0;
      bus_rdata  <= '0;
    end else begin
      ctrl       <= next_ctrl;
      force_insn <= next_force_insn;
      stage_insn <= next_stage_insn;
      stage_ext  <= next_stage_ext;
      bus_rdata  <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable program store, written at the processor's current address
  for (genvar i = 0; i < STORE_DEPTH; i++) begin : g_store
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        store[i] <= '0;
      end else if (commit_wr && ctrl[CTRL_ONBOARD] && idx == STORE_IDX_W'(i)) begin
        store[i] <= '{breakpoint_flag: bus_wdata[COMMIT_BREAKPOINT_FLAG], ext: stage_ext, insn: stage_insn};
      end
    end
  end

  // expansion store write pulse when the on-board store is disabled
  logic [WPULSE_W-1:0] wcnt, next_wcnt;
  always_comb begin
    next_wcnt = (wcnt != '0) ? wcnt - WPULSE_W'(1) : '0;
    if (commit_wr && !ctrl[CTRL_ONBOARD]) begin
      next_wcnt = WPULSE_W'(WRITE_PULSE_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run/step state, moves only on machine clock falling edges
  logic step_pend, next_step_pend;
  logic run_gate;
  assign run_gate = ctrl[CTRL_RUN];

  always_comb begin
    next_step_pend = step_wr | (step_pend & ~fall);
    next_state     = state;
    if (fall) begin
      if (step_pend) begin
        next_state = run_gate ? ST_RUN : ST_STEP;
      end else begin
        case (state)
          ST_STEP: next_state = ST_HALTED;
          ST_RUN: begin
            if (!run_gate || cur_word.breakpoint_flag || !xhalt_s2) begin
              next_state = ST_HALTED;
            end
          end
          ST_HALTED: next_state = ST_HALTED;
          default:   next_state = ST_HALTED;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state             <= ST_HALTED;
      step_pend         <= 1'b0;
      wcnt              <= '0;
      proc_halt_n       <= 1'b0;
      proc_reset_n      <= 1'b1;
      coproc_mclk       <= 1'b1;
      insn_out          <= '0;
      insn_oe           <= 1'b0;
      ext_store_write_n <= 1'b1;
    end else begin
      state             <= next_state;
      step_pend         <= next_step_pend;
      wcnt              <= next_wcnt;
      proc_halt_n       <= (next_state != ST_HALTED);
      proc_reset_n      <= ~(run_gate & ~xrst_s2);
      coproc_mclk       <= proc_halt_n ? mclk_s2 : 1'b1;
      insn_out          <= ctrl[CTRL_FORCE] ? store_word_s'{breakpoint_flag: 1'b0, ext: '0, insn: force_insn}
                                            : cur_word;
      insn_oe           <= ctrl[CTRL_FORCE] | ctrl[CTRL_ONBOARD];
      ext_store_write_n <= (next_wcnt == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_halt_state;
    !proc_halt_n && !(fall && step_pend) |=> !proc_halt_n;
  endproperty
  a_halt_state: assert property (p_halt_state)
    else $error("halt released while halted");

  property p_step_one;
    fall && !step_pend && state == ST_STEP |=> state == ST_HALTED ##1 !proc_halt_n;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("single step ran more than one cycle");

  property p_step_start;
    fall && step_pend && !run_gate |=> state == ST_STEP && proc_halt_n;
  endproperty
  a_step_start: assert property (p_step_start)
    else $error("step pulse did not release halt");

  property p_run_keep;
    fall && !step_pend && state == ST_RUN && run_gate && !cur_word.breakpoint_flag && xhalt_s2
      |=> state == ST_RUN;
  endproperty
  a_run_keep: assert property (p_run_keep)
    else $error("run mode stopped without cause");

  property p_breakpoint_flag_stop;
    fall && !step_pend && state == ST_RUN && cur_word.breakpoint_flag |=> ##1 !proc_halt_n;
  endproperty
  a_breakpoint_flag_stop: assert property (p_breakpoint_flag_stop)
    else $error("breakpoint did not halt");

  property p_edge_only;
    !fall |=> $stable(state);
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("state moved off a falling edge");

  property p_reset_gate;
    !run_gate |=> proc_reset_n;
  endproperty
  a_reset_gate: assert property (p_reset_gate)
    else $error("external reset passed in wait mode");

  property p_coproc_gate;
    !proc_halt_n |=> coproc_mclk;
  endproperty
  a_coproc_gate: assert property (p_coproc_gate)
    else $error("coprocessor clock ran while halted");

  property p_ext_write;
    commit_wr && !ctrl[CTRL_ONBOARD] |=> !ext_store_write_n [*4] ##1 ext_store_write_n;
  endproperty
  a_ext_write: assert property (p_ext_write)
    else $error("expansion write pulse wrong length");

  property p_store_breakpoint_flag;
    commit_wr && ctrl[CTRL_ONBOARD] |=> store[$past(idx)].breakpoint_flag == $past(bus_wdata[0]);
  endproperty
  a_store_breakpoint_flag: assert property (p_store_breakpoint_flag)
    else $error("breakpoint flag not stored");

  property p_force_sel;
    ctrl[CTRL_FORCE] |=> insn_out.insn == $past(force_insn);
  endproperty
  a_force_sel: assert property (p_force_sel)
    else $error("forced instruction not presented");

  c_single_step: cover property (fall && step_pend && !run_gate ##[1:200] state == ST_HALTED);
  c_run_breakpoint_flag:    cover property (state == ST_RUN ##[1:400] fall && cur_word.breakpoint_flag);
  c_forced:      cover property (ctrl[CTRL_FORCE] && proc_halt_n);

endmodule : run_step_breakpoint_control

// [proc_model.sv]
/*
  processor stand-in: free-running machine clock and a program address.
  assumes halt comes from the control block; jump forces a new address.
*/
`timescale 1ns/100ps
module proc_model
  import run_step_pkg::*;
(
  input  wire logic                   halt_n,
  input  wire logic                   jump,
  input  wire logic [PROC_ADDR_W-1:0] jump_addr,
  output logic                        mclk,
  output logic      [PROC_ADDR_W-1:0] addr
);
  logic go;
  initial begin
    mclk = 1'h1;
    addr = '0;
    go   = 1'h0;
  end
  always #200 mclk = ~mclk;
  // halt sampled mid cycle; address held while it is low
  always @(posedge mclk) go <= halt_n;
  always @(negedge mclk) begin
    if (jump) begin
      addr <= jump_addr;
    end else if (go) begin
      addr <= addr + 1'h1;
    end
  end
endmodule : proc_model

// [run_step_breakpoint_control_bench.sv]
/*
  self-checking bench: bus tasks, store and address model, processor stand-in.
  assumes the package register map and a 40 MHz sys_clk.
*/
`timescale 1ns/100ps
module run_step_breakpoint_control_bench
  import run_step_pkg::*;
;
  logic                   sys_clk         = 1'h0;
  logic                   rst_n           = 1'h0;
  logic [BUS_ADDR_W-1:0]  bus_addr        = '0;
  logic [BUS_DATA_W-1:0]  bus_wdata       = '0;
  logic                   bus_wr          = 1'h0;
  logic                   bus_rd          = 1'h0;
  logic                   ext_halt_n_pin  = 1'h1;
  logic                   ext_reset_n_pin = 1'h1;
  logic                   jump            = 1'h0;
  logic [PROC_ADDR_W-1:0] jump_addr       = '0;
  logic [BUS_DATA_W-1:0]  bus_rdata;
  logic [PROC_ADDR_W-1:0] proc_addr_pin;
  logic                   mclk_pin, proc_halt_n, proc_reset_n, coproc_mclk;
  logic                   insn_oe, ext_store_write_n;
  store_word_s            insn_out;
  logic [24:0]            mem [STORE_DEPTH];
  logic [31:0]            seed = 32'h3E2DB0D1;
  logic [31:0]            r;
  logic [7:0]             a;
  int                     num_errors = 0, total_checks = 0, low_cnt = 0, pc = 0;

  run_step_breakpoint_control run_step_breakpoint_control_inst (
    .sys_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .mclk_pin, .proc_addr_pin, .ext_halt_n_pin, .ext_reset_n_pin, .proc_halt_n,
    .proc_reset_n, .coproc_mclk, .insn_out, .insn_oe, .ext_store_write_n);
  proc_model proc_model_inst (
    .halt_n(proc_halt_n), .jump, .jump_addr, .mclk(mclk_pin), .addr(proc_addr_pin));

  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (ext_store_write_n === 1'h0) low_cnt++;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    bus_addr  <= ad;
    bus_wdata <= d;
    bus_wr    <= 1'h1;
    @(posedge sys_clk);
    bus_wr <= 1'h0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    bus_addr <= ad;
    bus_rd   <= 1'h1;
    @(posedge sys_clk);
    bus_rd <= 1'h0;
    @(negedge sys_clk);
    chk(bus_rdata, exp);
    @(posedge sys_clk);
  endtask : rchk
  task automatic wait_mc(input int n);
    repeat (n) @(negedge mclk_pin);
    repeat (8) @(posedge sys_clk);
  endtask : wait_mc
  task automatic jumpto(input logic [PROC_ADDR_W-1:0] v);
    jump      <= 1'h1;
    jump_addr <= v;
    @(negedge mclk_pin);
    @(posedge sys_clk);
    jump <= 1'h0;
    repeat (8) @(posedge sys_clk);
  endtask : jumpto
  task automatic commit_at(input logic [PROC_ADDR_W-1:0] v, input logic b);
    logic [31:0] d;
    d = rnd();
    jumpto(v);
    wr(REG_INSN, d[15:0]);
    wr(REG_EXT, {8'h0, d[23:16]});
    wr(REG_COMMIT, {15'h0, b});
    mem[v[7:0]] = {b, d[23:0]};
  endtask : commit_at
  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    for (int i = 0; i < STORE_DEPTH; i++) mem[i] = '0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(negedge sys_clk);
    chk(proc_halt_n, 0);
    @(posedge sys_clk);
    rchk(REG_CTRL, 32'h8);
    rchk(8'h18, 0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      a = {1'h1, r[6:0]};
      commit_at(13'(a) + 13'(i * 256), i[0]);
      jumpto(13'(a) + 13'h200);
      chk(insn_out, mem[a]);
      rchk(REG_INSN, mem[a][15:0]);
      rchk(REG_EXT, mem[a][23:16]);
      rchk(REG_COMMIT, mem[a][24]);
    end
    commit_at(13'h24, 1'h1);
    commit_at(13'h25, 1'h1);
    jumpto(13'h20);
    pc = 'h20;
    repeat (2) begin
      wr(REG_CTRL, 16'hA);
      wait_mc(3);
      pc++;
      chk(proc_addr_pin, pc);
      chk(proc_halt_n, 0);
    end
    rchk(REG_STATUS, {pc[7:0], 8'h0});
    repeat (40) begin @(posedge sys_clk); chk(coproc_mclk, 1); end
    wr(REG_CTRL, 16'hB);
    wait_mc(6);
    chk(proc_addr_pin, 13'h24);
    wr(REG_CTRL, 16'hB);
    wait_mc(4);
    chk(proc_addr_pin, 13'h25);
    rchk(REG_STATUS, 32'h2508);
    wr(REG_CTRL, 16'hB);
    wait_mc(2);
    chk(proc_halt_n, 1);
    @(negedge mclk_pin);
    repeat (4) @(posedge sys_clk);
    chk(coproc_mclk, 0);
    @(posedge mclk_pin);
    repeat (4) @(posedge sys_clk);
    chk(coproc_mclk, 1);
    wr(REG_CTRL, 16'h8);
    wait_mc(2);
    chk(proc_halt_n, 0);
    pc = int'(proc_addr_pin);
    wait_mc(2);
    chk(proc_addr_pin, pc);
    ext_reset_n_pin <= 1'h0;
    wait_mc(1);
    chk(proc_reset_n, 1);
    wr(REG_CTRL, 16'h9);
    wait_mc(1);
    chk(proc_reset_n, 0);
    ext_reset_n_pin <= 1'h1;
    wr(REG_CTRL, 16'hB);
    wait_mc(1);
    ext_halt_n_pin <= 1'h0;
    wait_mc(2);
    chk(proc_halt_n, 0);
    ext_halt_n_pin <= 1'h1;
    wr(REG_CTRL, 16'h8);
    r = rnd();
    wr(REG_FORCE, r[15:0]);
    wr(REG_CTRL, 16'hC);
    repeat (3) @(posedge sys_clk);
    chk(insn_out, {9'h0, r[15:0]});
    chk(insn_oe, 1);
    wr(REG_CTRL, 16'h0);
    low_cnt = 0;
    wr(REG_COMMIT, 16'h1);
    repeat (8) @(posedge sys_clk);
    chk(low_cnt, WRITE_PULSE_CYC);
    chk(insn_oe, 0);
    summarize();
  end
endmodule : run_step_breakpoint_control_bench
